// File: logic/cpirq_regs.vh
// register offsets, field positions and reset values of the protection irq block
`ifndef CPIRQ_REGS_VH
`define CPIRQ_REGS_VH

// ---------------------------------------------
// offsets
// ---------------------------------------------
`define CPIRQ_OFF_ENABLES   8'hC6
`define CPIRQ_OFF_STATUS    8'hC7
`define CPIRQ_OFF_IDENT0    8'hF0
`define CPIRQ_OFF_IDENT1    8'hF1
`define CPIRQ_OFF_IDENT2    8'hF2
`define CPIRQ_OFF_IDENT3    8'hF3
`define CPIRQ_OFF_IDENT4    8'hF4
`define CPIRQ_OFF_IDENT5    8'hF5

// ---------------------------------------------
// bit positions (status and enables share them)
// ---------------------------------------------
`define CPIRQ_BIT_GLOBAL    0
`define CPIRQ_BIT_PASS      1
`define CPIRQ_BIT_FAIL      2
`define CPIRQ_BIT_KSV       3
`define CPIRQ_BIT_LIST      4
`define CPIRQ_BIT_RXINT     5
`define CPIRQ_BIT_DETECT    6
`define CPIRQ_BIT_INDACC    7

// ---------------------------------------------
// reset value and source field range
// ---------------------------------------------
`define CPIRQ_RST_BYTE      8'h00
`define CPIRQ_SRC_MSB       7
`define CPIRQ_SRC_LSB       1

`endif

// File: logic/cpirq_flag.v
// one sticky status flag with set-over-clear
module cpirq_flag (
    clk,
    resetn,
    set_pulse,
    clr_pulse,
    flag
);
    input  wire clk;
    input  wire resetn;
    input  wire set_pulse;
    input  wire clr_pulse;
    output reg  flag;

    // set wins so no event is lost during a read
    always @(posedge clk) begin
        if (!resetn)
            flag <= 1'b0;
        else if (set_pulse)
            flag <= 1'b1;
        else if (clr_pulse)
            flag <= 1'b0;
    end
endmodule // cpirq_flag

// File: logic/cpirq_status.v
// protection irq status, enables and identification bytes
module cpirq_status #(
    // identification values are arbitrary, only chosen to tell the bytes apart
    parameter [7:0] IDENT_0       = 8'h41, // arbitrary value
    parameter [7:0] IDENT_1       = 8'h4A, // arbitrary value
    parameter [7:0] IDENT_CAPABLE = 8'h43, // arbitrary value
    parameter [7:0] IDENT_PLAIN   = 8'h44, // arbitrary value
    parameter [7:0] IDENT_3       = 8'h45, // arbitrary value
    parameter [7:0] IDENT_4       = 8'h46, // arbitrary value
    parameter [7:0] IDENT_5       = 8'h47  // arbitrary value
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       protect_capable,
    input  wire       ev_list_ready,
    input  wire       ev_key_vector_ready,
    input  wire       ev_verification_fail,
    input  wire       ev_verification_pass,
    input  wire       ev_downstream_request,
    input  wire       ev_receiver_detect,
    input  wire       ev_indirect_done,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output wire       irq
);
    `include "cpirq_regs.vh"

    // ---------------------------------------------
    // address decode
    // ---------------------------------------------
    // one compare shared by the write and clear paths
    function addr_is (
        input [7:0] addr,
        input [7:0] offset
    );
        addr_is = (addr == offset);
    endfunction

    // masked or of the source flags against their enables
    function any_enabled (
        input [7:1] flags,
        input [7:1] gates
    );
        any_enabled = |(flags & gates);
    endfunction

    wire       enables_wr;
    wire       status_rd;
    assign enables_wr = reg_wr && addr_is(reg_addr, `CPIRQ_OFF_ENABLES);
    assign status_rd  = reg_rd && addr_is(reg_addr, `CPIRQ_OFF_STATUS);

    // ---------------------------------------------
    // enables
    // ---------------------------------------------
    reg  [7:0] protect_irq_enables_r;
    reg  [7:0] protect_irq_enables_nxt;
    always @* begin
        protect_irq_enables_nxt = protect_irq_enables_r;
        if (enables_wr) begin
            protect_irq_enables_nxt = reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            protect_irq_enables_r <= `CPIRQ_RST_BYTE;
        end else begin
            protect_irq_enables_r <= protect_irq_enables_nxt;
        end
    end

    // ---------------------------------------------
    // per-source enable fields
    // ---------------------------------------------
    wire       global_gate;
    wire       verification_pass_gate;
    wire       verification_failure_gate;
    wire       key_vector_ready_gate;
    wire       list_ready_gate;
    wire       downstream_request_gate;
    wire       receiver_detect_gate;
    wire       indirect_access_done_gate;
    assign global_gate               = protect_irq_enables_r[`CPIRQ_BIT_GLOBAL];
    assign verification_pass_gate    = protect_irq_enables_r[`CPIRQ_BIT_PASS];
    assign verification_failure_gate = protect_irq_enables_r[`CPIRQ_BIT_FAIL];
    assign key_vector_ready_gate     = protect_irq_enables_r[`CPIRQ_BIT_KSV];
    assign list_ready_gate           = protect_irq_enables_r[`CPIRQ_BIT_LIST];
    assign downstream_request_gate   = protect_irq_enables_r[`CPIRQ_BIT_RXINT];
    assign receiver_detect_gate      = protect_irq_enables_r[`CPIRQ_BIT_DETECT];
    assign indirect_access_done_gate = protect_irq_enables_r[`CPIRQ_BIT_INDACC];

    // ---------------------------------------------
    // sticky source flags
    // ---------------------------------------------
    // a status read clears all seven; an event on the same edge still lands
    wire       verification_pass_flag;
    wire       verification_failure_flag;
    wire       key_vector_ready_flag;
    wire       list_ready_flag;
    wire       downstream_request_flag;
    wire       receiver_detect_flag;
    wire       indirect_access_done_flag;

    cpirq_flag u_pass_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_verification_pass),
        .clr_pulse (status_rd),
        .flag      (verification_pass_flag)
    );

    cpirq_flag u_fail_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_verification_fail),
        .clr_pulse (status_rd),
        .flag      (verification_failure_flag)
    );

    cpirq_flag u_key_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_key_vector_ready),
        .clr_pulse (status_rd),
        .flag      (key_vector_ready_flag)
    );

    cpirq_flag u_list_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_list_ready),
        .clr_pulse (status_rd),
        .flag      (list_ready_flag)
    );

    cpirq_flag u_down_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_downstream_request),
        .clr_pulse (status_rd),
        .flag      (downstream_request_flag)
    );

    cpirq_flag u_detect_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_receiver_detect),
        .clr_pulse (status_rd),
        .flag      (receiver_detect_flag)
    );

    cpirq_flag u_access_flag (
        .clk       (clk),
        .resetn    (resetn),
        .set_pulse (ev_indirect_done),
        .clr_pulse (status_rd),
        .flag      (indirect_access_done_flag)
    );

    // ---------------------------------------------
    // global flag and irq line
    // ---------------------------------------------
    wire [7:1] source_flags;
    wire [7:1] source_gates;
    wire       global_flag;
    wire [7:0] protect_irq_status;
    assign source_flags[`CPIRQ_BIT_PASS]   = verification_pass_flag;
    assign source_flags[`CPIRQ_BIT_FAIL]   = verification_failure_flag;
    assign source_flags[`CPIRQ_BIT_KSV]    = key_vector_ready_flag;
    assign source_flags[`CPIRQ_BIT_LIST]   = list_ready_flag;
    assign source_flags[`CPIRQ_BIT_RXINT]  = downstream_request_flag;
    assign source_flags[`CPIRQ_BIT_DETECT] = receiver_detect_flag;
    assign source_flags[`CPIRQ_BIT_INDACC] = indirect_access_done_flag;
    assign source_gates[`CPIRQ_BIT_PASS]   = verification_pass_gate;
    assign source_gates[`CPIRQ_BIT_FAIL]   = verification_failure_gate;
    assign source_gates[`CPIRQ_BIT_KSV]    = key_vector_ready_gate;
    assign source_gates[`CPIRQ_BIT_LIST]   = list_ready_gate;
    assign source_gates[`CPIRQ_BIT_RXINT]  = downstream_request_gate;
    assign source_gates[`CPIRQ_BIT_DETECT] = receiver_detect_gate;
    assign source_gates[`CPIRQ_BIT_INDACC] = indirect_access_done_gate;

    assign global_flag = any_enabled(source_flags, source_gates);
    assign protect_irq_status[`CPIRQ_BIT_GLOBAL] = global_flag;
    assign protect_irq_status[`CPIRQ_SRC_MSB:`CPIRQ_SRC_LSB] = source_flags;
    // global enable only gates the pin, so software can still poll bit 0
    assign irq = global_flag & global_gate;

    // ---------------------------------------------
    // read path
    // ---------------------------------------------
    wire [7:0] ident_byte_2;
    assign ident_byte_2 = protect_capable ? IDENT_CAPABLE : IDENT_PLAIN;

    // captured on the clearing edge, so a read reports exactly what it clears
    reg  [7:0] rdata_nxt;
    always @* begin
        rdata_nxt = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `CPIRQ_OFF_ENABLES: rdata_nxt = protect_irq_enables_r;
                `CPIRQ_OFF_STATUS:  rdata_nxt = protect_irq_status;
                `CPIRQ_OFF_IDENT0:  rdata_nxt = IDENT_0;
                `CPIRQ_OFF_IDENT1:  rdata_nxt = IDENT_1;
                `CPIRQ_OFF_IDENT2:  rdata_nxt = ident_byte_2;
                `CPIRQ_OFF_IDENT3:  rdata_nxt = IDENT_3;
                `CPIRQ_OFF_IDENT4:  rdata_nxt = IDENT_4;
                `CPIRQ_OFF_IDENT5:  rdata_nxt = IDENT_5;
                default:            rdata_nxt = `CPIRQ_RST_BYTE;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= `CPIRQ_RST_BYTE;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end
endmodule // cpirq_status

// File: test/cpirq_status_checker.sv
// port-level assertions for the protection irq status block
module cpirq_status_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       protect_capable,
    input wire logic       irq,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       ev_list_ready,
    input wire logic       ev_key_vector_ready,
    input wire logic       ev_verification_fail,
    input wire logic       ev_verification_pass,
    input wire logic       ev_downstream_request,
    input wire logic       ev_receiver_detect,
    input wire logic       ev_indirect_done,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] en_r;
    wire        rd_st = reg_rd && reg_addr == 8'hC7;
    // shadow of the enables, since they are only visible through reads
    always @(posedge clk)
        if (!resetn) en_r <= 8'h00;
        else if (reg_wr && reg_addr == 8'hC6) en_r <= reg_wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // a status read one idle cycle after the event
    sequence s_rd; !reg_rd ##1 rd_st; endsequence
    property p_list; ev_list_ready ##1 s_rd |=> reg_rdata[4]; endproperty
    a_list: assert property (p_list) else $error("list flag lost");
    property p_ksv; ev_key_vector_ready ##1 s_rd |=> reg_rdata[3]; endproperty
    a_ksv: assert property (p_ksv) else $error("key flag lost");
    property p_fail; ev_verification_fail ##1 s_rd |=> reg_rdata[2]; endproperty
    a_fail: assert property (p_fail) else $error("fail flag lost");
    property p_pass; ev_verification_pass ##1 s_rd |=> reg_rdata[1]; endproperty
    a_pass: assert property (p_pass) else $error("pass flag lost");
    property p_ind; ev_indirect_done ##1 s_rd |=> reg_rdata[7]; endproperty
    a_ind: assert property (p_ind) else $error("access flag lost");
    property p_rx; ev_downstream_request ##1 s_rd |=> reg_rdata[5]; endproperty
    a_rx: assert property (p_rx) else $error("downstream flag lost");
    property p_det; ev_receiver_detect ##1 s_rd |=> reg_rdata[6]; endproperty
    a_det: assert property (p_det) else $error("detect flag lost");
    property p_glob; rd_st |=> reg_rdata[0] == |(reg_rdata[7:1] & $past(en_r[7:1])); endproperty
    a_glob: assert property (p_glob) else $error("global flag wrong");
    property p_gate; irq |-> en_r[0]; endproperty
    a_gate: assert property (p_gate) else $error("irq not gated");
    property p_id; reg_rd && reg_addr == 8'hF2 && protect_capable |=> reg_rdata == 8'h43; endproperty
    a_id: assert property (p_id) else $error("ident byte wrong");
    c_irq: cover property (irq);
    c_clr: cover property (rd_st ##1 reg_rdata != 8'h00);
    c_id: cover property (reg_rd && reg_addr == 8'hF2);
endmodule // cpirq_status_checker

bind cpirq_status cpirq_status_checker u_chk (
    .clk                   (clk),
    .resetn                (resetn),
    .protect_capable       (protect_capable),
    .irq                   (irq),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .ev_list_ready         (ev_list_ready),
    .ev_key_vector_ready   (ev_key_vector_ready),
    .ev_verification_fail  (ev_verification_fail),
    .ev_verification_pass  (ev_verification_pass),
    .ev_downstream_request (ev_downstream_request),
    .ev_receiver_detect    (ev_receiver_detect),
    .ev_indirect_done      (ev_indirect_done),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata)
);

// File: test/tb_cpirq_status.sv
// self-checking bench for the protection irq status block
module tb_cpirq_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, resetn = 0, protect_capable = 1, reg_wr = 0, reg_rd = 0;
    logic [7:1] ev = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, d;
    wire  [7:0] reg_rdata;
    wire        irq;
    int         bad_count = 0, checked = 0;
    cpirq_status uut (
        .clk                   (clk),
        .resetn                (resetn),
        .protect_capable       (protect_capable),
        .ev_list_ready         (ev[4]),
        .ev_key_vector_ready   (ev[3]),
        .ev_verification_fail  (ev[2]),
        .ev_verification_pass  (ev[1]),
        .ev_downstream_request (ev[5]),
        .ev_receiver_detect    (ev[6]),
        .ev_indirect_done      (ev[7]),
        .reg_addr              (reg_addr),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata),
        .irq                   (irq)
    );
    initial forever #5 clk = ~clk;
    task chk(input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // each access waits a fresh falling edge, so no strobe is driven twice at once
    task rdchk(input logic [7:0] a, e);
        @(negedge clk) reg_addr = a;
        reg_rd = 1;
        @(negedge clk) reg_rd = 0;
        chk(reg_rdata, e);
    endtask
    task wr(input logic [7:0] a, v);
        @(negedge clk) reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        @(negedge clk) reg_wr = 0;
    endtask
    task pulse(input logic [7:1] v);
        @(negedge clk) ev = v;
        @(negedge clk) ev = 0;
    endtask
    task t_sources;
        logic [7:0] m;
        for (int i = 1; i < 8; i++) begin
            m = 8'h01 << i;
            pulse(m[7:1]);
            rdchk(8'hC7, m);
            rdchk(8'hC7, 8'h00);
        end
    endtask
    // event and status read on one edge: the event must survive the clear
    task t_race;
        @(negedge clk) ev = 7'h01;
        reg_addr = 8'hC7;
        reg_rd = 1;
        @(negedge clk) ev = 0;
        reg_rd = 0;
        chk(reg_rdata, 8'h00);
        rdchk(8'hC7, 8'h02);
    endtask
    // reset in mid-run drops flags, enables and the irq line
    task t_reset;
        wr(8'hC6, 8'h03);
        pulse(7'h01);
        chk({7'h0, irq}, 8'h01);
        @(negedge clk) resetn = 0;
        @(negedge clk) resetn = 1;
        chk({7'h0, irq}, 8'h00);
        rdchk(8'hC6, 8'h00);
        rdchk(8'hC7, 8'h00);
    endtask
    task t_irq;
        wr(8'hC6, 8'h05);
        pulse(7'h03);
        chk({7'h0, irq}, 8'h01);
        rdchk(8'hC7, 8'h07);
        chk({7'h0, irq}, 8'h00);
        wr(8'hC6, 8'h04);
        pulse(7'h02);
        chk({7'h0, irq}, 8'h00);
        rdchk(8'hC7, 8'h05);
        wr(8'hF0, 8'hFF);
        rdchk(8'hF0, 8'h41);
        rdchk(8'hC6, 8'h04);
        rdchk(8'h10, 8'h00);
    endtask
    task t_ident;
        logic [7:0] id [6];
        id = '{8'h41, 8'h4A, 8'h43, 8'h45, 8'h46, 8'h47};
        for (int i = 0; i < 6; i++) rdchk(8'(8'hF0 + i), id[i]);
        protect_capable = 0;
        rdchk(8'hF2, 8'h44);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1;
        rdchk(8'hC6, 8'h00);
        rdchk(8'hC7, 8'h00);
        t_sources;
        t_race;
        t_irq;
        t_reset;
        t_ident;
        final_report;
    end
    // run needs about 100 cycles
    initial begin
        #20000;
        bad_count++;
        final_report;
    end
endmodule // tb_cpirq_status
